// file: rtl/spi_pkg.sv
package spi_pkg;
    // Register offsets on the plain register port
    localparam logic [7:0] CTRL_ADDR = 8'h10;
    localparam logic [7:0] STAT_ADDR = 8'h11;
    localparam logic [7:0] DATA_ADDR = 8'h12;

    // Control register bit positions
    localparam int C_RXIE = 7;
    localparam int C_MSTR = 5;
    localparam int C_CLOCK_IDLE_LEVEL = 4;
    localparam int C_CLOCK_EDGE_PHASE = 3;
    localparam int C_ODRN = 2;
    localparam int C_ENAB = 1;
    localparam int C_TXIE = 0;

    // Status and control register bit positions
    localparam int S_RXF = 7;
    localparam int S_ERIE = 6;
    localparam int S_OVR = 5;
    localparam int S_FLT = 4;
    localparam int S_TXE = 3;
    localparam int S_FDEN = 2;
    localparam int S_RHI = 1;
    localparam int S_RLO = 0;

    // Reset values of the two control registers
    localparam logic [7:0] CTRL_RESET = 8'h28;
    localparam logic [7:0] STAT_RESET = 8'h08;

    // Half serial clock period in base clock cycles, per rate code
    localparam logic [7:0] DIV_00 = 8'h02;
    localparam logic [7:0] DIV_01 = 8'h08;
    localparam logic [7:0] DIV_10 = 8'h20;
    localparam logic [7:0] DIV_11 = 8'h80;

    // Transfer counts
    localparam logic [3:0] LAST_SAMPLE = 4'h7;
    localparam logic [4:0] LAST_EDGE = 5'h0f;

    typedef enum logic {IDLE, XFER} phase_t;

    // Complete state of the register block and shifter
    typedef struct packed {
        logic rx_full_irq_en;
        logic master_select;
        logic clock_idle_level;
        logic clock_edge_phase;
        logic open_drain_sel;
        logic module_enable;
        logic tx_empty_irq_en;
        logic error_irq_en;
        logic select_fault_detect_en;
        logic [1:0] rate_sel;
        logic rx_full_flag;
        logic overrun_flag;
        logic select_fault_flag;
        logic tx_empty_flag;
        logic rx_arm;
        logic ovr_arm;
        logic flt_arm;
        logic [7:0] tx_hold;
        logic [7:0] rx_hold;
        logic [7:0] shift_reg;
        logic out_bit;
        logic sh_loaded;
        phase_t phase;
        logic [4:0] edge_cnt;
        logic [3:0] smp_cnt;
        logic sck_lvl;
        logic sck_prev;
        logic [7:0] rd_data;
    } port_state_t;

    typedef struct packed {
        logic [7:0] cnt;
    } div_state_t;

    typedef struct packed {
        logic ss_prev;
    } mon_state_t;
endpackage

// file: rtl/port_ctl_if.sv
`timescale 1ns/1ps
interface port_ctl_if;
    logic [1:0] rate_sel;
    logic run;
    logic tick;
    logic enable;
    logic master;
    logic detect_en;
    logic ss_n;
    logic busy;
    logic fault_set;
    logic ss_free;

    modport ctrl (
        output rate_sel, run, enable, master, detect_en, ss_n, busy,
        input tick, fault_set, ss_free
    );
    modport div (input rate_sel, run, output tick);
    modport mon (input enable, master, detect_en, ss_n, busy, output fault_set, ss_free);
endinterface

// file: rtl/rate_divider.sv
`timescale 1ns/1ps
module rate_divider (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Control link
    port_ctl_if.div link
);
    spi_pkg::div_state_t s;
    spi_pkg::div_state_t next_s;
    logic [7:0] half;

    // Half period of the serial clock from the rate code
    always_comb begin
        unique case (link.rate_sel)
            2'b00: half = spi_pkg::DIV_00;
            2'b01: half = spi_pkg::DIV_01;
            2'b10: half = spi_pkg::DIV_10;
            2'b11: half = spi_pkg::DIV_11;
        endcase
    end

    // Toggle request every half period, giving clock / (2 x divisor)
    assign link.tick = link.run && (s.cnt == half - 8'h01);

    always_comb begin
        next_s = s;
        if (reset_i || !link.run || link.tick) begin
            next_s.cnt = 8'h00;
        end else begin
            next_s.cnt = s.cnt + 8'h01;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        s <= next_s;
    end
endmodule

// file: rtl/select_monitor.sv
`timescale 1ns/1ps
module select_monitor (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Control link
    port_ctl_if.mon link
);
    spi_pkg::mon_state_t s;
    spi_pkg::mon_state_t next_s;
    logic rose;

    assign rose = link.ss_n && !s.ss_prev;

    // Fault detection by mode; the enable only gates new faults
    always_comb begin
        link.fault_set = 1'b0;
        if (link.enable && link.detect_en) begin
            if (link.master) begin
                link.fault_set = !link.ss_n;
            end else begin
                link.fault_set = rose && link.busy;
            end
        end
    end

    // Select pin is free for general use unless the port needs it
    assign link.ss_free = !link.enable || (link.master && !link.detect_en);

    always_comb begin
        next_s = s;
        next_s.ss_prev = reset_i ? 1'b1 : link.ss_n;
    end

    always_ff @(posedge sys_clk_i) begin
        s <= next_s;
    end
endmodule

// file: rtl/spi_master_slave_registers.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module spi_master_slave_registers (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Interrupt requests
    output logic rx_irq_o,
    output logic tx_irq_o,
    output logic err_irq_o,
    // Serial clock pin
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_o,
    // Master-out pin
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_o,
    // Master-in pin
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_o,
    // Slave select and pad control
    input wire logic ss_n_i,
    output logic ss_free_o,
    output logic pullup_en_o
);
    spi_pkg::port_state_t s;
    spi_pkg::port_state_t next_s;
    port_ctl_if link();

    // Decoded strobes and clear steps
    logic ctl_wr;
    logic st_wr;
    logic dat_wr;
    logic ctl_rd;
    logic st_rd;
    logic dat_rd;
    logic clr_rx;
    logic clr_ov;
    logic clr_flt;

    // Serial clock edges and shifter
    logic slave_act;
    logic lead;
    logic trail;
    logic smp_edge;
    logic drv_edge;
    logic din;
    logic done;
    logic [7:0] shifted;

    // Pin drive enables
    logic drive_m;
    logic drive_s;

    rate_divider u_div (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .link(link)
    );

    select_monitor u_mon (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .link(link)
    );

    // Control values handed to divider and select monitor
    assign link.rate_sel = s.rate_sel;
    assign link.run = s.module_enable && s.master_select && (s.phase == spi_pkg::XFER);
    assign link.enable = s.module_enable;
    assign link.master = s.master_select;
    assign link.detect_en = s.select_fault_detect_en;

    // Select monitor sees the raw pin and whether a byte is part done
    assign link.ss_n = ss_n_i;
    assign link.busy = s.smp_cnt != 4'h0;

    // Register port decode
    assign ctl_wr = wr_i && (addr_i == spi_pkg::CTRL_ADDR);
    assign st_wr = wr_i && (addr_i == spi_pkg::STAT_ADDR);
    assign dat_wr = wr_i && (addr_i == spi_pkg::DATA_ADDR);
    assign ctl_rd = rd_i && (addr_i == spi_pkg::CTRL_ADDR);
    assign st_rd = rd_i && (addr_i == spi_pkg::STAT_ADDR);
    assign dat_rd = rd_i && (addr_i == spi_pkg::DATA_ADDR);

    // Second step of the two-step clear sequences
    assign clr_rx = dat_rd && s.rx_arm;
    assign clr_ov = dat_rd && s.ovr_arm;
    assign clr_flt = ctl_wr && s.flt_arm;

    // Serial clock edges: master from its own divider ticks, slave from the pin
    assign slave_act = s.module_enable && !s.master_select && !ss_n_i;
    always_comb begin
        lead = 1'b0;
        trail = 1'b0;
        if (s.master_select) begin
            // Master edges come from its own divider ticks
            if (link.tick) begin
                lead = !s.edge_cnt[0];
                trail = s.edge_cnt[0];
            end
        end else if (slave_act) begin
            // Slave edges are seen on the pin only while selected
            lead = (s.sck_prev == s.clock_idle_level) && (sclk_i != s.clock_idle_level);
            trail = (s.sck_prev != s.clock_idle_level) && (sclk_i == s.clock_idle_level);
        end
    end

    // Phase 0 samples on the leading edge, phase 1 on the trailing one
    assign smp_edge = s.clock_edge_phase ? trail : lead;
    assign drv_edge = s.clock_edge_phase ? lead : trail;
    assign din = s.master_select ? miso_i : mosi_i;
    assign shifted = {s.shift_reg[6:0], din};
    assign done = s.module_enable && smp_edge && (s.smp_cnt == spi_pkg::LAST_SAMPLE);

    always_comb begin
        next_s = s;
        // Read data idles at zero; pin history follows the clock pin
        next_s.rd_data = 8'h00;
        next_s.sck_prev = sclk_i;

        // Register reads answer in the next cycle only; unmapped reads give zero
        if (ctl_rd) begin
            next_s.rd_data[spi_pkg::C_RXIE] = s.rx_full_irq_en;
            next_s.rd_data[spi_pkg::C_MSTR] = s.master_select;
            next_s.rd_data[spi_pkg::C_CLOCK_IDLE_LEVEL] = s.clock_idle_level;
            next_s.rd_data[spi_pkg::C_CLOCK_EDGE_PHASE] = s.clock_edge_phase;
            next_s.rd_data[spi_pkg::C_ODRN] = s.open_drain_sel;
            next_s.rd_data[spi_pkg::C_ENAB] = s.module_enable;
            next_s.rd_data[spi_pkg::C_TXIE] = s.tx_empty_irq_en;
        end
        if (st_rd) begin
            next_s.rd_data[spi_pkg::S_RXF] = s.rx_full_flag;
            next_s.rd_data[spi_pkg::S_ERIE] = s.error_irq_en;
            next_s.rd_data[spi_pkg::S_OVR] = s.overrun_flag;
            next_s.rd_data[spi_pkg::S_FLT] = s.select_fault_flag;
            next_s.rd_data[spi_pkg::S_TXE] = s.tx_empty_flag;
            next_s.rd_data[spi_pkg::S_FDEN] = s.select_fault_detect_en;
            next_s.rd_data[spi_pkg::S_RHI] = s.rate_sel[1];
            next_s.rd_data[spi_pkg::S_RLO] = s.rate_sel[0];
            // First step: remember which flags this read saw set
            next_s.rx_arm = s.rx_full_flag;
            next_s.ovr_arm = s.overrun_flag;
            next_s.flt_arm = s.select_fault_flag;
        end
        if (dat_rd) begin
            next_s.rd_data = s.rx_hold;
            next_s.rx_arm = 1'b0;
            next_s.ovr_arm = 1'b0;
        end

        // Clears first, so any set further down wins
        if (clr_rx) begin
            next_s.rx_full_flag = 1'b0;
        end
        if (clr_ov) begin
            next_s.overrun_flag = 1'b0;
        end
        if (ctl_wr) begin
            next_s.flt_arm = 1'b0;
            if (clr_flt) begin
                next_s.select_fault_flag = 1'b0;
            end
        end

        // Control register write
        if (ctl_wr) begin
            next_s.rx_full_irq_en = wdata_i[spi_pkg::C_RXIE];
            next_s.master_select = wdata_i[spi_pkg::C_MSTR];
            next_s.clock_idle_level = wdata_i[spi_pkg::C_CLOCK_IDLE_LEVEL];
            next_s.clock_edge_phase = wdata_i[spi_pkg::C_CLOCK_EDGE_PHASE];
            next_s.open_drain_sel = wdata_i[spi_pkg::C_ODRN];
            next_s.module_enable = wdata_i[spi_pkg::C_ENAB];
            next_s.tx_empty_irq_en = wdata_i[spi_pkg::C_TXIE];
        end

        // Status and control register write; flags are read-only
        if (st_wr) begin
            next_s.error_irq_en = wdata_i[spi_pkg::S_ERIE];
            next_s.select_fault_detect_en = wdata_i[spi_pkg::S_FDEN];
            next_s.rate_sel = {wdata_i[spi_pkg::S_RHI], wdata_i[spi_pkg::S_RLO]};
        end

        // Data write fills the transmit holding register only
        if (dat_wr) begin
            next_s.tx_hold = wdata_i;
            next_s.tx_empty_flag = 1'b0;
        end

        if (!s.module_enable) begin
            // Disabled: shifter parked, control bits and sticky flags kept
            next_s.phase = spi_pkg::IDLE;
            next_s.edge_cnt = 5'h00;
            next_s.smp_cnt = 4'h0;
            next_s.sh_loaded = 1'b0;
            next_s.tx_empty_flag = 1'b1;
            next_s.sck_lvl = s.clock_idle_level;
        end else begin
            // Slave with select high ignores the clock and drops a partial byte
            if (!s.master_select && ss_n_i) begin
                next_s.smp_cnt = 4'h0;
            end

            // Sample edge shifts one bit in; drive edge presents the next bit out
            if (smp_edge) begin
                next_s.shift_reg = shifted;
                next_s.smp_cnt = s.smp_cnt + 4'h1;
            end
            if (drv_edge) begin
                next_s.out_bit = s.shift_reg[7];
            end

            // Master clock toggles on each tick and returns to idle after sixteen edges
            if (s.master_select) begin
                if (s.phase == spi_pkg::XFER) begin
                    if (link.tick) begin
                        next_s.sck_lvl = !s.sck_lvl;
                        next_s.edge_cnt = s.edge_cnt + 5'h01;
                        if (s.edge_cnt == spi_pkg::LAST_EDGE) begin
                            // Sixteenth edge ends the frame and frees the shifter
                            next_s.phase = spi_pkg::IDLE;
                            next_s.sh_loaded = 1'b0;
                        end
                    end
                end else begin
                    next_s.sck_lvl = s.clock_idle_level;
                end
            end else begin
                next_s.phase = spi_pkg::IDLE;
                next_s.sck_lvl = s.clock_idle_level;
            end

            // Eighth sample completes the byte
            if (done) begin
                next_s.smp_cnt = 4'h0;
                if (!s.master_select) begin
                    next_s.sh_loaded = 1'b0;
                end
                // Unread byte: keep it, drop the new one, flag the overrun
                if (s.rx_full_flag && !clr_rx) begin
                    next_s.overrun_flag = 1'b1;
                end else begin
                    next_s.rx_hold = shifted;
                    next_s.rx_full_flag = 1'b1;
                end
            end

            // Pending transmit byte moves to the shifter when it is free
            if (!s.tx_empty_flag && !s.sh_loaded) begin
                if (s.master_select ? (s.phase == spi_pkg::IDLE)
                        : (s.smp_cnt == 4'h0 && !lead && !trail)) begin
                    next_s.shift_reg = s.tx_hold;
                    next_s.out_bit = s.tx_hold[7];
                    next_s.sh_loaded = 1'b1;
                    next_s.tx_empty_flag = 1'b1;
                    if (s.master_select) begin
                        next_s.phase = spi_pkg::XFER;
                        next_s.edge_cnt = 5'h00;
                    end
                end
            end
        end

        // Select fault is sticky and beats a coincident clear
        if (link.fault_set) begin
            next_s.select_fault_flag = 1'b1;
        end

        // Synchronous reset; holding registers keep their contents
        if (reset_i) begin
            next_s = '0;
            next_s.tx_hold = s.tx_hold;
            next_s.rx_hold = s.rx_hold;
            next_s.rx_full_irq_en = spi_pkg::CTRL_RESET[spi_pkg::C_RXIE];
            next_s.master_select = spi_pkg::CTRL_RESET[spi_pkg::C_MSTR];
            next_s.clock_idle_level = spi_pkg::CTRL_RESET[spi_pkg::C_CLOCK_IDLE_LEVEL];
            next_s.clock_edge_phase = spi_pkg::CTRL_RESET[spi_pkg::C_CLOCK_EDGE_PHASE];
            next_s.open_drain_sel = spi_pkg::CTRL_RESET[spi_pkg::C_ODRN];
            next_s.module_enable = spi_pkg::CTRL_RESET[spi_pkg::C_ENAB];
            next_s.tx_empty_irq_en = spi_pkg::CTRL_RESET[spi_pkg::C_TXIE];
            next_s.tx_empty_flag = spi_pkg::STAT_RESET[spi_pkg::S_TXE];
            next_s.sck_prev = 1'b0;
            next_s.phase = spi_pkg::IDLE;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        s <= next_s;
    end

    // Interrupt requests from flags gated by their enables
    assign rx_irq_o = s.rx_full_flag && s.rx_full_irq_en;
    assign tx_irq_o = s.tx_empty_flag && s.tx_empty_irq_en;
    assign err_irq_o = (s.overrun_flag || s.select_fault_flag) && s.error_irq_en;

    // Pin drive; open drain only pulls low, the pad resolves the high level
    assign drive_m = s.module_enable && s.master_select;
    assign drive_s = slave_act;
    assign sclk_o = s.sck_lvl;
    assign mosi_o = s.out_bit;
    assign miso_o = s.out_bit;

    // Enables; in open drain a high level is left to the pad
    assign sclk_oe_o = drive_m && (!s.open_drain_sel || !s.sck_lvl);
    assign mosi_oe_o = drive_m && (!s.open_drain_sel || !s.out_bit);
    assign miso_oe_o = drive_s && (!s.open_drain_sel || !s.out_bit);

    // Pad pullups, select pin status and read data
    assign pullup_en_o = !s.open_drain_sel;
    assign ss_free_o = link.ss_free;
    assign rdata_o = s.rd_data;
endmodule

// file: test/spi_peer_model.sv
`timescale 1ns/1ps
module spi_peer_model #(
    parameter logic IDLE_LVL = 1'b0
) (
    // Serial pins of the selected slave
    input wire logic sclk_i,
    input wire logic mosi_i,
    output logic miso_o,
    // Byte exchange with the bench
    input wire logic [7:0] tx_byte_i,
    output logic [7:0] rx_byte_o,
    output logic [7:0] done_cnt_o
);
    logic lead;
    logic [2:0] bit_cnt = 3'h0;
    logic [2:0] lead_cnt = 3'h0;
    logic [7:0] shift = 8'h00;
    logic out_bit = 1'b0;
    logic released = 1'b1;

    // Start-up values of the byte outputs
    initial begin
        rx_byte_o = 8'h00;
        done_cnt_o = 8'h00;
    end

    // Leading edge taken against the agreed idle level
    assign lead = sclk_i ^ IDLE_LVL;

    // Phase 1: drive the next bit on the leading edge
    always @(posedge lead) begin
        out_bit <= (bit_cnt == 3'h0) ? tx_byte_i[7] : shift[7];
        shift <= (bit_cnt == 3'h0) ? {tx_byte_i[6:0], 1'b0} : {shift[6:0], 1'b0};
        lead_cnt <= lead_cnt + 3'h1;
        released <= 1'b0;
    end

    // Sample on the trailing edge, close the byte after eight clocks
    always @(negedge lead) begin
        if (lead_cnt == bit_cnt + 3'h1) begin
            rx_byte_o <= {rx_byte_o[6:0], mosi_i};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
                done_cnt_o <= done_cnt_o + 8'h01;
                released <= 1'b1;
            end
        end
    end

    // A released line shows the inverse of the last bit
    assign miso_o = released ? ~out_bit : out_bit;
endmodule

// file: test/spi_master_slave_registers_properties.sv
`timescale 1ns/1ps
module spi_master_slave_registers_properties (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // Interrupt requests
    input wire logic rx_irq_o,
    input wire logic tx_irq_o,
    input wire logic err_irq_o,
    // Serial pins
    input wire logic sclk_i,
    input wire logic sclk_o,
    input wire logic sclk_oe_o,
    input wire logic mosi_i,
    input wire logic mosi_o,
    input wire logic mosi_oe_o,
    input wire logic miso_i,
    input wire logic miso_o,
    input wire logic miso_oe_o,
    input wire logic ss_n_i,
    input wire logic ss_free_o,
    input wire logic pullup_en_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    // Control write carrying a given bit value
    sequence ctrl_wr_s(int b, logic v);
        wr_i && addr_i == spi_pkg::CTRL_ADDR && wdata_i[b] == v;
    endsequence

    // Serial clock edge outside a register write
    sequence toggle_s;
        $changed(sclk_o) && !wr_i;
    endsequence

    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data not zero outside read cycle");
    rx_irq_off_a: assert property (ctrl_wr_s(spi_pkg::C_RXIE, 1'b0) |=> !rx_irq_o)
        else $error("receive interrupt with enable clear");
    tx_irq_off_a: assert property (ctrl_wr_s(spi_pkg::C_TXIE, 1'b0) |=> !tx_irq_o)
        else $error("transmit interrupt with enable clear");
    err_irq_off_a: assert property (wr_i && addr_i == spi_pkg::STAT_ADDR
        && !wdata_i[spi_pkg::S_ERIE] |=> !err_irq_o) else $error("error interrupt not gated");
    tx_empty_clr_a: assert property (wr_i && addr_i == spi_pkg::DATA_ADDR
        && tx_irq_o |=> !tx_irq_o) else $error("data write left transmit empty");
    open_drain_a: assert property (ctrl_wr_s(spi_pkg::C_ODRN, 1'b1) |=> !pullup_en_o)
        else $error("pullups kept in open drain mode");
    od_low_only_a: assert property (!pullup_en_o && mosi_oe_o |-> !mosi_o)
        else $error("open drain pin driven high");
    port_off_a: assert property (ctrl_wr_s(spi_pkg::C_ENAB, 1'b0)
        |=> (!sclk_oe_o && !mosi_oe_o && ss_free_o)) else $error("pins driven when off");
    miso_float_a: assert property (ss_n_i && $past(ss_n_i) |-> !miso_oe_o)
        else $error("master-in driven while not selected");
    sclk_half_a: assert property (toggle_s |=> $stable(sclk_o))
        else $error("serial clock half period below two cycles");
    reset_idle_a: assert property ($fell(reset_i) |-> !sclk_o && !sclk_oe_o && pullup_en_o)
        else $error("pins not idle after reset");
endmodule

bind spi_master_slave_registers spi_master_slave_registers_properties u_props (
    .sys_clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rx_irq_o, .tx_irq_o,
    .err_irq_o, .sclk_i, .sclk_o, .sclk_oe_o, .mosi_i, .mosi_o, .mosi_oe_o, .miso_i, .miso_o,
    .miso_oe_o, .ss_n_i, .ss_free_o, .pullup_en_o
);

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    // Design side signals
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic ss_n_i = 1'b1;
    logic [7:0] rdata_o;
    logic rx_irq_o, tx_irq_o, err_irq_o, sclk_o, sclk_oe_o, mosi_o, mosi_oe_o;
    logic miso_o, miso_oe_o, ss_free_o, pullup_en_o, sclk_i, mosi_i, miso_i, peer_miso;
    logic [7:0] peer_tx = 8'h00;
    logic [7:0] peer_rx, peer_done, v, d, p;
    logic [7:0] bd_tab[4] = '{8'h02, 8'h08, 8'h20, 8'h80};
    // Bench bookkeeping
    int error_cnt = 0;
    int n_checks = 0;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'h000158e4;

    // Wire levels: clock pulled down, master-out pulled up
    assign sclk_i = sclk_oe_o ? sclk_o : 1'b0;
    assign mosi_i = mosi_oe_o ? mosi_o : 1'b1;
    assign miso_i = miso_oe_o ? miso_o : peer_miso;

    always #5 sys_clk_i = ~sys_clk_i;

    spi_master_slave_registers dut (.sys_clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .rx_irq_o, .tx_irq_o, .err_irq_o, .sclk_i, .sclk_o, .sclk_oe_o, .mosi_i,
        .mosi_o, .mosi_oe_o, .miso_i, .miso_o, .miso_oe_o, .ss_n_i, .ss_free_o, .pullup_en_o);
    spi_peer_model peer (.sclk_i(sclk_i), .mosi_i(mosi_i), .miso_o(peer_miso),
        .tx_byte_i(peer_tx), .rx_byte_o(peer_rx), .done_cnt_o(peer_done));

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] dv);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= dv;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    // A read notes its expected data; the watcher compares it
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
    endtask

    // Read data stands in the cycle after the strobe
    always @(posedge sys_clk_i) begin
        if (rd_seen) chk("rdata", rdata_o, exp_q.pop_front());
        rd_seen <= rd_i;
    end

    // One master byte: half period measured, peer byte compared
    task automatic xfer(input logic [7:0] dv, input logic [7:0] pv, input logic [7:0] bd);
        logic [7:0] n0;
        logic lvl;
        int n;
        n0 = peer_done;
        peer_tx = pv;
        wr(spi_pkg::DATA_ADDR, dv);
        n = 0;
        lvl = sclk_o;
        while (sclk_o === lvl && n < 300) begin
            @(negedge sys_clk_i);
            n++;
        end
        n = 0;
        lvl = sclk_o;
        do begin
            @(negedge sys_clk_i);
            n++;
        end while (sclk_o === lvl && n < 300);
        chk("half period", n[7:0], bd);
        n = 0;
        while (peer_done === n0 && n < 5000) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk("peer done", peer_done, n0 + 8'h01);
        repeat (4) @(negedge sys_clk_i);
        chk("peer byte", peer_rx, dv);
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (40000) @(posedge sys_clk_i);
        error_cnt++;
        finish_test();
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        rd(spi_pkg::CTRL_ADDR, 8'h28);
        rd(spi_pkg::STAT_ADDR, 8'h08);
        v = rnd() & 8'h9d;
        wr(spi_pkg::CTRL_ADDR, v);
        wr(8'h13, 8'hff);
        rd(spi_pkg::CTRL_ADDR, v);
        wr(spi_pkg::CTRL_ADDR, 8'hab);
        @(negedge sys_clk_i);
        chk("ss free", ss_free_o, 8'h01);
        chk("clock drive", sclk_oe_o, 8'h01);
        for (int r = 0; r < 4; r++) begin
            wr(spi_pkg::STAT_ADDR, r[7:0]);
            d = rnd();
            p = rnd();
            xfer(d, p, bd_tab[r]);
            chk("rx irq", rx_irq_o, 8'h01);
            chk("tx irq", tx_irq_o, 8'h01);
            rd(spi_pkg::STAT_ADDR, 8'h88 | r[7:0]);
            rd(spi_pkg::DATA_ADDR, p);
            rd(spi_pkg::STAT_ADDR, 8'h08 | r[7:0]);
        end
        // Second byte lands while the first is unread
        wr(spi_pkg::STAT_ADDR, 8'h00);
        d = rnd();
        p = rnd();
        xfer(d, p, 8'h02);
        xfer(~d, rnd(), 8'h02);
        rd(spi_pkg::STAT_ADDR, 8'ha8);
        rd(spi_pkg::DATA_ADDR, p);
        rd(spi_pkg::STAT_ADDR, 8'h08);
        // Select pulled low under a master with detection on
        wr(spi_pkg::STAT_ADDR, 8'h44);
        @(negedge sys_clk_i);
        chk("ss free", ss_free_o, 8'h00);
        @(posedge sys_clk_i);
        ss_n_i <= 1'b0;
        @(posedge sys_clk_i);
        ss_n_i <= 1'b1;
        repeat (3) @(negedge sys_clk_i);
        chk("err irq", err_irq_o, 8'h01);
        wr(spi_pkg::STAT_ADDR, 8'h40);
        rd(spi_pkg::STAT_ADDR, 8'h58);
        wr(spi_pkg::CTRL_ADDR, 8'hab);
        rd(spi_pkg::STAT_ADDR, 8'h48);
        // Slave: master-in floats until selected
        wr(spi_pkg::CTRL_ADDR, 8'h0a);
        wr(spi_pkg::DATA_ADDR, d);
        @(negedge sys_clk_i);
        chk("miso drive", miso_oe_o, 8'h00);
        chk("clock drive", sclk_oe_o, 8'h00);
        @(posedge sys_clk_i);
        ss_n_i <= 1'b0;
        repeat (3) @(negedge sys_clk_i);
        chk("miso drive", miso_oe_o, 8'h01);
        chk("miso bit", miso_o, {7'h00, d[7]});
        @(posedge sys_clk_i);
        ss_n_i <= 1'b1;
        wr(spi_pkg::CTRL_ADDR, 8'h2e);
        @(negedge sys_clk_i);
        chk("pullups", pullup_en_o, 8'h00);
        wr(spi_pkg::CTRL_ADDR, 8'h28);
        repeat (2) @(negedge sys_clk_i);
        chk("clock drive", sclk_oe_o, 8'h00);
        chk("pullups", pullup_en_o, 8'h01);
        finish_test();
    end
endmodule
